// [verilog/spi_cmd_pkg.sv]
// opcodes, phase types and command format table for the flash command decoder
`default_nettype none
package spi_cmd_pkg;
   // opcodes
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_SEQ_A = 8'hAD;
   localparam logic [7:0] OP_SEQ_B = 8'hAF;
   localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
   localparam logic [7:0] OP_PROG_QUAD = 8'h32;
   localparam logic [7:0] OP_SUSP_A = 8'h75;
   localparam logic [7:0] OP_SUSP_B = 8'hB0;
   localparam logic [7:0] OP_RESM_A = 8'h7A;
   localparam logic [7:0] OP_RESM_B = 8'hD0;
   localparam logic [7:0] OP_WRAP = 8'h77;
   localparam logic [7:0] OP_WR_EN = 8'h06;
   localparam logic [7:0] OP_WR_DIS = 8'h04;
   localparam logic [7:0] OP_VOL_WREN = 8'h50;
   localparam logic [7:0] OP_BLK_LOCK = 8'h36;
   localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
   localparam logic [7:0] OP_BLK_RD_A = 8'h3C;
   localparam logic [7:0] OP_BLK_RD_B = 8'h3D;
   localparam logic [7:0] OP_ALL_LOCK = 8'h7E;
   localparam logic [7:0] OP_ALL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_OTP_PROG = 8'h9B;
   localparam logic [7:0] OP_OTP_READ = 8'h4B;
   localparam logic [7:0] OP_SR1_RD = 8'h05;
   localparam logic [7:0] OP_SR2_RD = 8'h35;
   localparam logic [7:0] OP_SR3_RD = 8'h15;
   localparam logic [7:0] OP_SR_IDX_RD = 8'h65;
   localparam logic [7:0] OP_SR1_WR = 8'h01;
   localparam logic [7:0] OP_SR2_WR = 8'h31;
   localparam logic [7:0] OP_SR3_WR = 8'h11;
   localparam logic [7:0] OP_SR_IDX_WR = 8'h71;
   localparam logic [7:0] OP_SR_LOCK = 8'h6F;
   localparam logic [7:0] OP_DEEP_PD = 8'hB9;
   localparam logic [7:0] OP_ULTRA_PD = 8'h79;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_TERM = 8'hF0;
   localparam logic [7:0] OP_ID = 8'h90;
   localparam logic [7:0] OP_ID_QUAD = 8'h94;
   // byte limits and status index
   localparam logic [8:0] PAGE_MAX = 9'h100;
   localparam logic [8:0] OTP_MAX = 9'h080;
   localparam logic [8:0] SR_COUNT = 9'h005;
   localparam logic [7:0] SR_FIRST_IDX = 8'h01;
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_IGNORE} phase_type;

   typedef struct packed {
      logic valid;
      logic [1:0] addrBytes;
      logic [2:0] addrLines;
      logic [3:0] dummyClocks;
      logic [2:0] dataLines;
      logic dataWrite;
      logic dataRead;
      logic [8:0] maxBytes;
   } cmd_info_type;

   // one format entry
   function automatic cmd_info_type mk(input logic [1:0] ab, input logic [2:0] al,
         input logic [3:0] dc, input logic [2:0] dl, input logic wr, input logic rd,
         input logic [8:0] mx);
      cmd_info_type c;
      c = {1'b1, ab, al, dc, dl, wr, rd, mx};
      return c;
   endfunction : mk

   // opcode to transfer format; seq drops the address of later sequential frames
   function automatic cmd_info_type decode(input logic [7:0] op, input logic seq);
      cmd_info_type c;
      c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b0, 1'b0, 9'h000);
      case (op)
         OP_PROG: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, PAGE_MAX);
         OP_SEQ_A, OP_SEQ_B: c = mk(seq ? 2'h0 : 2'h3, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h001);
         OP_PROG_DUAL: c = mk(2'h3, 3'h1, 4'h0, 3'h2, 1'b1, 1'b0, PAGE_MAX);
         OP_PROG_QUAD: c = mk(2'h3, 3'h1, 4'h0, 3'h4, 1'b1, 1'b0, PAGE_MAX);
         OP_SUSP_A, OP_SUSP_B: c.valid = 1'b1;
         OP_RESM_A, OP_RESM_B: c.valid = 1'b1;
         OP_WRAP: c = mk(2'h3, 3'h4, 4'h0, 3'h4, 1'b1, 1'b0, 9'h001);
         OP_WR_EN, OP_WR_DIS: c.valid = 1'b1;
         OP_VOL_WREN: c.valid = 1'b1;
         OP_BLK_LOCK, OP_BLK_UNLOCK: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b0, 1'b0, 9'h000);
         OP_BLK_RD_A, OP_BLK_RD_B: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b0, 1'b1, 9'h001);
         OP_ALL_LOCK, OP_ALL_UNLOCK: c.valid = 1'b1;
         OP_OTP_PROG: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, OTP_MAX);
         OP_OTP_READ: c = mk(2'h3, 3'h1, 4'h8, 3'h1, 1'b0, 1'b1, OTP_MAX);
         OP_SR1_RD, OP_SR2_RD, OP_SR3_RD: c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b0, 1'b1, 9'h001);
         OP_SR_IDX_RD: c = mk(2'h1, 3'h1, 4'h8, 3'h1, 1'b0, 1'b1, 9'h001);
         OP_SR1_WR: c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h002);
         OP_SR2_WR, OP_SR3_WR: c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h001);
         OP_SR_IDX_WR: c = mk(2'h1, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h001);
         OP_SR_LOCK: c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h002);
         OP_DEEP_PD, OP_ULTRA_PD: c.valid = 1'b1;
         OP_WAKE: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b0, 1'b1, 9'h001);
         OP_RST_EN, OP_RST: c.valid = 1'b1;
         OP_TERM: c = mk(2'h0, 3'h1, 4'h0, 3'h1, 1'b1, 1'b0, 9'h001);
         OP_ID: c = mk(2'h3, 3'h1, 4'h0, 3'h1, 1'b0, 1'b1, 9'h002);
         OP_ID_QUAD: c = mk(2'h3, 3'h4, 4'h2, 3'h4, 1'b0, 1'b1, 9'h002);
         default: c.valid = 1'b0;
      endcase
      return c;
   endfunction : decode

   // phase that follows address and dummy
   function automatic phase_type dataPhase(input cmd_info_type c);
      return c.dataWrite ? PH_WDATA : (c.dataRead ? PH_RDATA : PH_IGNORE);
   endfunction : dataPhase
endpackage : spi_cmd_pkg
`default_nettype wire

// [verilog/byte_fifo.sv]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q, rdPtr_q;
   logic [AW:0] count_q;
   logic doPush, doPop;

   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;
   assign outData = mem[rdPtr_q];

   // storage has no reset; pointers, count and flags take one
   always_ff @(posedge ref_clk)
   begin
      if (doPush)
         mem[wrPtr_q] <= inData;
   end

   // pointers, count and registered flags
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         inReady <= 1'b0;
         outValid <= 1'b0;
      end
      else
      begin
         if (doPush)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (doPop)
            rdPtr_q <= rdPtr_q + 1'b1;
         count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
         inReady <= (count_q + (AW+1)'(doPush) - (AW+1)'(doPop)) != (AW+1)'(DEPTH);
         outValid <= (count_q + (AW+1)'(doPush) - (AW+1)'(doPop)) != '0;
      end
   end
endmodule : byte_fifo
`default_nettype wire

// [verilog/spi_flash_command_decoder.sv]
// spi slave command decoder: frames, phases, write-data fifo and read-data shifter
// Operation
// - 02h page program, 3 address, 1-256 bytes
// - A2h program, data on two lines
// - 32h program, data on four lines
// - 75h/B0h suspend, command only
// - 7Ah/D0h resume, command only
// - 77h wrap setup, address and data quad
// - 50h volatile status write enable
// - 36h/39h block lock/unlock with address
// - 3Ch/3Dh block lock read, one byte
// - 7Eh lock all, 98h unlock all
// - 9Bh otp program, 1-128 bytes
// - 4Bh otp read with dummy byte
// - 05h/35h/15h read status one byte
// - 65h indexed status read, index, dummy
// - 01h write status, two bytes; 31h/11h one byte
// - 71h indexed status write, one byte
// - 6Fh status lock, two data bytes
// - B9h/79h enter power-down states
// - ABh wake, or with address returns id
// - 66h then 99h reset; F0h terminate
// - 90h/94h id read, two bytes
// - format gives lines per phase
// - index 01h reads all five registers
// - B9h depth chosen by select bit
// - reset pair is two separate frames
`timescale 1ns/1ns
`default_nettype none
module spi_flash_command_decoder (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic csN,
   input wire logic sck,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   input wire logic powerDownDepthSelect,
   output logic [7:0] curOpcode,
   output logic rdReq,
   output logic [7:0] rdIndex,
   input wire logic [7:0] rdData,
   output logic wrValid,
   output logic [8:0] wrData,
   input wire logic wrReady,
   output logic dataLost,
   output logic cmdDone,
   output logic [7:0] cmdCode,
   output logic [23:0] cmdAddr,
   output logic [8:0] cmdBytes,
   output logic deepPowerDown,
   output logic ultraPowerDown,
   output logic softReset
);
   logic csS1, csS2, csS3, sckS1, sckS2, sckS3;
   logic [3:0] ioS1, ioS2;
   logic sckRise, sckFall, frameEnd, abWake;
   spi_cmd_pkg::phase_type phase_q;
   spi_cmd_pkg::cmd_info_type info_q, newInfo;
   logic [7:0] shift_q, shNext, outShift_q, outWord;
   logic [3:0] bitCnt_q, bitsNext;
   logic [2:0] w, outBits_q;
   logic [8:0] byteCnt_q;
   logic [1:0] addrCnt_q;
   logic [3:0] dummyCnt_q;
   logic [23:0] addr_q;
   logic byteDone, addrDone_q, cmdSeen_q, seqActive_q, resetArmed_q;
   logic push_q, fifoInReady;
   logic [8:0] pushData_q;

   // shift one sample of w lines in, msb first
   function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic [3:0] io,
         input logic [2:0] lines);
      case (lines)
         3'h4: return {sh[3:0], io};
         3'h2: return {sh[5:0], io[1:0]};
         default: return {sh[6:0], io[0]};
      endcase
   endfunction : shiftIn

   // two flops on every pin before use
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         csS1 <= 1'b1;
         csS2 <= 1'b1;
         csS3 <= 1'b1;
         sckS1 <= 1'b0;
         sckS2 <= 1'b0;
         sckS3 <= 1'b0;
         ioS1 <= 4'h0;
         ioS2 <= 4'h0;
      end
      else
      begin
         csS1 <= csN;
         csS2 <= csS1;
         csS3 <= csS2;
         sckS1 <= sck;
         sckS2 <= sckS1;
         sckS3 <= sckS2;
         ioS1 <= ioIn;
         ioS2 <= ioS1;
      end
   end

   // edges of the sampled clock; mode 0 and 3 both sample on the rise
   assign sckRise = sckS2 && !sckS3 && !csS2;
   assign sckFall = !sckS2 && sckS3 && !csS2;
   assign frameEnd = csS2 && !csS3;

   // lines of the current phase and the shifted byte
   always_comb
   begin
      case (phase_q)
         spi_cmd_pkg::PH_ADDR: w = info_q.addrLines;
         spi_cmd_pkg::PH_WDATA, spi_cmd_pkg::PH_RDATA: w = info_q.dataLines;
         default: w = 3'h1;
      endcase
      shNext = shiftIn(shift_q, ioS2, w);
      bitsNext = bitCnt_q + {1'b0, w};
      byteDone = bitsNext == 4'h8;
      newInfo = spi_cmd_pkg::decode(shNext, seqActive_q);
      outWord = (outBits_q == 3'h0) ? rdData : outShift_q;
   end

   // ab with no address bits at all is the plain wake form
   assign abWake = (info_q.addrBytes != 2'h0) && (phase_q == spi_cmd_pkg::PH_ADDR)
      && (curOpcode == spi_cmd_pkg::OP_WAKE) && (addrCnt_q == 2'h0) && (bitCnt_q == 4'h0);

   // phase sequencer on sampled clock rises; chip select high clears the frame
   always_ff @(posedge ref_clk)
   begin
      rdReq <= 1'b0;
      push_q <= 1'b0;
      if (!rstn || csS2)
      begin
         phase_q <= spi_cmd_pkg::PH_CMD;
         bitCnt_q <= 4'h0;
         byteCnt_q <= 9'h000;
         addrCnt_q <= 2'h0;
         dummyCnt_q <= 4'h0;
         addrDone_q <= 1'b0;
         cmdSeen_q <= 1'b0;
         if (!rstn)
         begin
            shift_q <= 8'h00;
            addr_q <= 24'h00_0000;
            info_q <= '0;
            curOpcode <= 8'h00;
            rdIndex <= 8'h00;
            pushData_q <= 9'h000;
         end
      end
      else if (sckRise)
      begin
         case (phase_q)
            spi_cmd_pkg::PH_CMD:
            begin
               shift_q <= shNext;
               bitCnt_q <= byteDone ? 4'h0 : bitsNext;
               if (byteDone)
               begin
                  curOpcode <= shNext;
                  info_q <= newInfo;
                  cmdSeen_q <= newInfo.valid;
                  rdIndex <= 8'h00;
                  if (!newInfo.valid)
                     phase_q <= spi_cmd_pkg::PH_IGNORE;
                  else if (newInfo.addrBytes != 2'h0)
                     phase_q <= spi_cmd_pkg::PH_ADDR;
                  else
                  begin
                     phase_q <= spi_cmd_pkg::dataPhase(newInfo);
                     addrDone_q <= 1'b1;
                     rdReq <= newInfo.dataRead;
                  end
               end
            end
            spi_cmd_pkg::PH_ADDR:
            begin
               shift_q <= shNext;
               bitCnt_q <= byteDone ? 4'h0 : bitsNext;
               if (byteDone)
               begin
                  addr_q <= {addr_q[15:0], shNext};
                  addrCnt_q <= addrCnt_q + 2'h1;
                  if (addrCnt_q + 2'h1 == info_q.addrBytes)
                  begin
                     addrDone_q <= 1'b1;
                     if (curOpcode == spi_cmd_pkg::OP_SR_IDX_RD && shNext == spi_cmd_pkg::SR_FIRST_IDX)
                        info_q.maxBytes <= spi_cmd_pkg::SR_COUNT;
                     if (info_q.dummyClocks != 4'h0)
                        phase_q <= spi_cmd_pkg::PH_DUMMY;
                     else
                     begin
                        phase_q <= spi_cmd_pkg::dataPhase(info_q);
                        rdReq <= info_q.dataRead;
                     end
                  end
               end
            end
            spi_cmd_pkg::PH_DUMMY:
            begin
               dummyCnt_q <= dummyCnt_q + 4'h1;
               if (dummyCnt_q + 4'h1 == info_q.dummyClocks)
               begin
                  phase_q <= spi_cmd_pkg::dataPhase(info_q);
                  rdReq <= info_q.dataRead;
                  if (curOpcode == spi_cmd_pkg::OP_SR_IDX_RD)
                     rdIndex <= addr_q[7:0];
               end
            end
            spi_cmd_pkg::PH_WDATA:
            begin
               shift_q <= shNext;
               bitCnt_q <= byteDone ? 4'h0 : bitsNext;
               if (byteDone)
               begin
                  push_q <= 1'b1;
                  pushData_q <= {byteCnt_q == 9'h000, shNext};
                  byteCnt_q <= byteCnt_q + 9'h001;
                  if (byteCnt_q + 9'h001 == info_q.maxBytes)
                     phase_q <= spi_cmd_pkg::PH_IGNORE;
               end
            end
            spi_cmd_pkg::PH_RDATA:
            begin
               bitCnt_q <= byteDone ? 4'h0 : bitsNext;
               if (byteDone)
               begin
                  byteCnt_q <= byteCnt_q + 9'h001;
                  if (byteCnt_q + 9'h001 == info_q.maxBytes)
                     phase_q <= spi_cmd_pkg::PH_IGNORE;
                  else
                  begin
                     rdReq <= 1'b1;
                     rdIndex <= rdIndex + 8'h01;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // read data launched on falling edges so it is stable at the next rise
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || csS2)
      begin
         ioOe <= 4'h0;
         ioOut <= 4'h0;
         outBits_q <= 3'h0;
         outShift_q <= 8'h00;
      end
      else if (sckFall)
      begin
         if (phase_q == spi_cmd_pkg::PH_RDATA)
         begin
            outBits_q <= outBits_q + w;
            case (w)
               3'h4:
               begin
                  ioOut <= outWord[7:4];
                  ioOe <= 4'hF;
                  outShift_q <= {outWord[3:0], 4'h0};
               end
               3'h2:
               begin
                  ioOut <= {2'h0, outWord[7:6]};
                  ioOe <= 4'h3;
                  outShift_q <= {outWord[5:0], 2'h0};
               end
               default:
               begin
                  ioOut <= {2'h0, outWord[7], 1'b0};
                  ioOe <= 4'h2;
                  outShift_q <= {outWord[6:0], 1'b0};
               end
            endcase
         end
         else
         begin
            ioOe <= 4'h0;
            ioOut <= 4'h0;
         end
      end
   end

   // end of frame: report the command and raise the special events
   always_ff @(posedge ref_clk)
   begin
      cmdDone <= 1'b0;
      deepPowerDown <= 1'b0;
      ultraPowerDown <= 1'b0;
      softReset <= 1'b0;
      if (!rstn)
      begin
         cmdCode <= 8'h00;
         cmdAddr <= 24'h00_0000;
         cmdBytes <= 9'h000;
         seqActive_q <= 1'b0;
         resetArmed_q <= 1'b0;
      end
      else if (frameEnd && cmdSeen_q && (addrDone_q || abWake))
      begin
         // short address means no operation, so only whole headers land here
         cmdDone <= 1'b1;
         cmdCode <= curOpcode;
         cmdAddr <= addr_q;
         cmdBytes <= byteCnt_q;
         resetArmed_q <= curOpcode == spi_cmd_pkg::OP_RST_EN;
         softReset <= (curOpcode == spi_cmd_pkg::OP_RST) && resetArmed_q;
         deepPowerDown <= (curOpcode == spi_cmd_pkg::OP_DEEP_PD) && powerDownDepthSelect;
         ultraPowerDown <= (curOpcode == spi_cmd_pkg::OP_ULTRA_PD)
            || ((curOpcode == spi_cmd_pkg::OP_DEEP_PD) && !powerDownDepthSelect);
         if ((curOpcode == spi_cmd_pkg::OP_SEQ_A || curOpcode == spi_cmd_pkg::OP_SEQ_B)
               && byteCnt_q != 9'h000)
            seqActive_q <= 1'b1;
         else if (curOpcode == spi_cmd_pkg::OP_WR_DIS
               || (curOpcode == spi_cmd_pkg::OP_RST && resetArmed_q))
            seqActive_q <= 1'b0;
      end
      else if (frameEnd)
         resetArmed_q <= 1'b0;
   end

   // a byte that finds the fifo full cannot be held back on spi, so flag it
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         dataLost <= 1'b0;
      else
         dataLost <= push_q && !fifoInReady;
   end

   byte_fifo #(
      .WIDTH(spi_cmd_pkg::FIFO_WIDTH),
      .DEPTH(spi_cmd_pkg::FIFO_DEPTH)
   ) writeFifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .inValid(push_q),
      .inData(pushData_q),
      .inReady(fifoInReady),
      .outValid(wrValid),
      .outData(wrData),
      .outReady(wrReady)
   );
endmodule : spi_flash_command_decoder
`default_nettype wire

// [verif/spi_flash_command_decoder_asserts.sv]
// port-level checks for the flash command decoder
`timescale 1ns/1ns
`default_nettype none
module spi_flash_command_decoder_asserts (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic csN,
   input wire logic [3:0] ioOe,
   input wire logic powerDownDepthSelect,
   input wire logic [7:0] curOpcode,
   input wire logic rdReq,
   input wire logic wrValid,
   input wire logic [8:0] wrData,
   input wire logic wrReady,
   input wire logic dataLost,
   input wire logic cmdDone,
   input wire logic [7:0] cmdCode,
   input wire logic deepPowerDown,
   input wire logic ultraPowerDown,
   input wire logic softReset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // a report only once chip select has been high for a while
   chk_done_after_cs:
      assert property (cmdDone |-> csN && $past(csN, 2)) else $error("report inside a frame");
   chk_oe_idle:
      assert property (csN [*5] |-> ioOe == 4'h0) else $error("pin driven between frames");
   // reads drive SO alone, except the quad id read
   chk_read_lines:
      assert property (ioOe != 4'h0 |-> ioOe == (curOpcode == 8'h94 ? 4'hF : 4'h2))
         else $error("wrong output lines");
   chk_no_stray_out:
      assert property (ioOe != 4'h0 |-> curOpcode inside {8'h05, 8'h35, 8'h15, 8'h65, 8'h3C,
         8'h3D, 8'h4B, 8'h90, 8'h94, 8'hAB}) else $error("output for a non-read opcode");
   chk_deep_pd:
      assert property (deepPowerDown |-> cmdDone && cmdCode == 8'hB9 && powerDownDepthSelect)
         else $error("deep power-down without cause");
   chk_ultra_pd:
      assert property (ultraPowerDown |-> cmdDone && (cmdCode == 8'h79
         || cmdCode == 8'hB9 && !powerDownDepthSelect)) else $error("ultra power-down wrong");
   chk_soft_reset:
      assert property (softReset |-> cmdDone && cmdCode == 8'h99) else $error("reset without 99h");
   chk_rd_spacing:
      assert property (rdReq |-> !csN ##1 !rdReq [*8]) else $error("read request too close");
   // a stalled consumer must see the same word
   chk_wr_hold:
      assert property (wrValid && !wrReady |=> wrValid && $stable(wrData))
         else $error("fifo output changed while stalled");
   chk_lost_full:
      assert property (dataLost |-> wrValid) else $error("byte dropped with fifo empty");
endmodule : spi_flash_command_decoder_asserts
bind spi_flash_command_decoder spi_flash_command_decoder_asserts
   i_spi_flash_command_decoder_asserts (.ref_clk, .rstn, .csN, .ioOe, .powerDownDepthSelect,
   .curOpcode, .rdReq, .wrValid, .wrData, .wrReady, .dataLost, .cmdDone, .cmdCode,
   .deepPowerDown, .ultraPowerDown, .softReset);
`default_nettype wire

// [verif/spi_host_model.sv]
// host spi controller model: frames and bytes on 1, 2 or 4 lines
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   input wire logic ref_clk,
   output logic csN,
   output logic sck,
   output logic [3:0] hostIo,
   input wire logic [3:0] io
);
   initial
   begin
      csN = 1'b1;
      sck = 1'b0;
      hostIo = 4'h0;
   end
   // half of the 160 ns link period, just after a system edge
   task automatic half;
      repeat (20) @(posedge ref_clk);
      #1;
   endtask : half
   // each command gets its own chip-select frame
   task automatic open;
      csN = 1'b0;
      half;
   endtask : open
   // released lines show the inverse so no stale value passes
   task automatic close;
      csN = 1'b1;
      hostIo = ~hostIo;
      half;
   endtask : close
   // msb first, 8/lines clocks; sck idles low between frames
   task automatic xfer(input logic [7:0] b, input int lines, output logic [7:0] r);
      for (int k = 0; k < 8 / lines; k++)
      begin
         hostIo = lines == 4 ? b[7:4] : (lines == 2 ? {2'b00, b[7:6]} : {3'b000, b[7]});
         b = b << lines;
         half;
         sck = 1'b1;
         r = lines == 4 ? {r[3:0], io} : (lines == 2 ? {r[5:0], io[1:0]} : {r[6:0], io[1]});
         half;
         sck = 1'b0;
      end
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// [verif/spi_flash_command_decoder_tb.sv]
// self-checking bench for the flash command decoder
`timescale 1ns/1ns
`default_nettype none
module spi_flash_command_decoder_tb;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic powerDownDepthSelect = 1'b0;
   logic wrReady = 1'b0;
   logic [7:0] rdData = 8'h00;
   logic csN, sck, rdReq, wrValid, dataLost, cmdDone, deepPowerDown, ultraPowerDown, softReset;
   logic [3:0] hostIo, ioWire, ioOut, ioOe;
   logic [7:0] curOpcode, rdIndex, cmdCode, r;
   logic [8:0] wrData, cmdBytes;
   logic [23:0] cmdAddr;
   logic [2:0] lastPulse;
   logic [8:0] got [$];
   int error_cnt = 0;
   int checked = 0;
   int doneCnt = 0;
   int lostCnt = 0;
   int expDone = 0;
   always #2 ref_clk = ~ref_clk;
   // wire level from the decoder's enables; the host drives every line the decoder does not
   assign ioWire = (ioOe & ioOut) | (~ioOe & hostIo);
   spi_flash_command_decoder i_spi_flash_command_decoder (.ref_clk, .rstn, .csN, .sck,
      .ioIn(ioWire), .ioOut, .ioOe, .powerDownDepthSelect, .curOpcode, .rdReq, .rdIndex, .rdData,
      .wrValid, .wrData, .wrReady, .dataLost, .cmdDone, .cmdCode, .cmdAddr, .cmdBytes,
      .deepPowerDown, .ultraPowerDown, .softReset);
   spi_host_model i_spi_host_model (.ref_clk, .csN, .sck, .hostIo, .io(ioWire));
   // user side: read byte from opcode and index, pops, logs reports
   always @(posedge ref_clk)
   begin
      if (rdReq)
         rdData <= curOpcode ^ rdIndex;
      if (wrValid && wrReady)
         got.push_back(wrData);
      if (dataLost)
         lostCnt++;
      if (cmdDone)
         doneCnt++;
      if (cmdDone)
         lastPulse <= {deepPowerDown, ultraPowerDown, softReset};
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic done_is(input logic [7:0] op, input logic [8:0] n, input logic [2:0] p);
      expDone++;
      check(doneCnt, expDone);
      check(cmdCode, op);
      check(cmdBytes, n);
      check(lastPulse, p);
   endtask : done_is
   task automatic cmd_frame(input logic [7:0] op);
      i_spi_host_model.open;
      i_spi_host_model.xfer(op, 1, r);
      i_spi_host_model.close;
   endtask : cmd_frame
   // command-only opcodes, power-down depth and the reset pair
   task automatic t_cmd_only;
      logic [7:0] ops [11] = '{8'h06, 8'h04, 8'h50, 8'h7E, 8'h98, 8'h75, 8'hB0, 8'h7A, 8'hD0,
         8'hAB, 8'h66};
      for (int k = 0; k < 11; k++)
      begin
         cmd_frame(ops[k]);
         done_is(ops[k], 9'h000, 3'b000);
      end
      cmd_frame(8'h99);
      done_is(8'h99, 9'h000, 3'b001);
      cmd_frame(8'h99);
      done_is(8'h99, 9'h000, 3'b000);
      powerDownDepthSelect = 1'b1;
      cmd_frame(8'hB9);
      done_is(8'hB9, 9'h000, 3'b100);
      powerDownDepthSelect = 1'b0;
      cmd_frame(8'hB9);
      done_is(8'hB9, 9'h000, 3'b010);
      cmd_frame(8'h79);
      done_is(8'h79, 9'h000, 3'b010);
   endtask : t_cmd_only
   // program on 1/2/4 lines, wrap, otp, lock
   task automatic t_write;
      logic [7:0] ops [6] = '{8'h02, 8'hA2, 8'h32, 8'h77, 8'h9B, 8'h36};
      int al [6] = '{1, 1, 1, 4, 1, 1};
      int dl [6] = '{1, 2, 4, 4, 1, 1};
      int nd [6] = '{3, 3, 3, 1, 3, 0};
      wrReady = 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         got.delete();
         i_spi_host_model.open;
         i_spi_host_model.xfer(ops[k], 1, r);
         for (int a = 0; a < 3; a++)
            i_spi_host_model.xfer(8'h12 + 8'h22 * a[7:0], al[k], r);
         for (int d = 0; d < nd[k]; d++)
            i_spi_host_model.xfer(8'hC6 ^ d[7:0], dl[k], r);
         i_spi_host_model.close;
         done_is(ops[k], nd[k][8:0], 3'b000);
         check(cmdAddr, 24'h12_3456);
         check(got.size(), nd[k]);
         for (int d = 0; d < nd[k]; d++)
            check(got[d], {d == 0, 8'hC6 ^ d[7:0]});
      end
   endtask : t_write
   // read-type frames: header, dummy where the format has one, then the user bytes shifted back
   task automatic t_read;
      logic [7:0] ops [6] = '{8'h05, 8'h65, 8'h90, 8'h3C, 8'h94, 8'h4B};
      int na [6] = '{0, 1, 3, 3, 4, 4};
      int nr [6] = '{1, 5, 2, 1, 2, 2};
      int ln [6] = '{1, 1, 1, 1, 4, 1};
      int base;
      for (int k = 0; k < 6; k++)
      begin
         base = ops[k] == 8'h65 ? 1 : 0; // index 01h walks all registers
         i_spi_host_model.open;
         i_spi_host_model.xfer(ops[k], 1, r);
         for (int a = 0; a < na[k] + (k == 1 ? 1 : 0); a++)
            i_spi_host_model.xfer(8'h01, ln[k], r);
         for (int d = 0; d < nr[k]; d++)
         begin
            i_spi_host_model.xfer(8'h00, ln[k], r);
            check(r, ops[k] ^ (base + d));
         end
         i_spi_host_model.close;
         done_is(ops[k], nr[k][8:0], 3'b000);
      end
   endtask : t_read
   // unknown opcode, then a frame cut short in its address
   task automatic t_refuse;
      got.delete();
      i_spi_host_model.open;
      i_spi_host_model.xfer(8'hFF, 1, r);
      i_spi_host_model.xfer(8'h02, 1, r);
      i_spi_host_model.xfer(8'h05, 1, r);
      i_spi_host_model.close;
      cmd_frame(8'h02);
      check(doneCnt, expDone);
      check(got.size(), 0);
   endtask : t_refuse
   // stalled consumer: fill until refused, then drain while stalling
   task automatic t_fifo;
      got.delete();
      wrReady = 1'b0;
      i_spi_host_model.open;
      for (int b = 0; b < 38; b++)
         i_spi_host_model.xfer(b == 0 ? 8'h02 : b[7:0], 1, r);
      i_spi_host_model.close;
      done_is(8'h02, 9'h022, 3'b000);
      check(lostCnt, 2);
      for (int c = 0; c < 200; c++)
      begin
         @(posedge ref_clk);
         #1 wrReady = c[0];
      end
      check(got.size(), 32);
      check(got[0], 9'h104);
      check(got[31], 9'h023);
   endtask : t_fifo
   task automatic tally_and_finish;
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (4) @(posedge ref_clk);
      #1 rstn = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      t_cmd_only;
      t_write;
      t_read;
      t_refuse;
      t_fifo;
      tally_and_finish;
   end
   // watchdog: about twice the run
   initial
   begin
      repeat (90000) @(posedge ref_clk);
      error_cnt++;
      tally_and_finish;
   end
endmodule : spi_flash_command_decoder_tb
`default_nettype wire
